// ### uolc_pkg.sv
// Overview of operation
// - Cable status bit 7 high unless A-cable
// - Line stable bit needs 1 ms unchanged lines
// - B-valid status follows bus-voltage comparator
// - B-end status follows bus-voltage comparator
// - A-valid status bit 0 follows comparator
// - Control bits 7..4 drive four line resistors
// - Control bit 3 switches bus supply on
// - Line enable honoured only with controller enabled
// - Line enable off, device mode: D+ pull-up
// - Line enable off, host enabled: both pull-downs
// - Bits 1 and 0 charge, discharge supply
// - Stall flag set on stall handshake, W1C
// - Host attach flag after 2.5 us quiet
// - Resume flag after 2.5 us K state
// - Sleep flag after 3 ms idle; activity restarts
// - Token flag set when token finishes, W1C
// - Token clear loads held status, same-cycle new status or zero
// - Frame flag on frame token or threshold
// - Error flag on any detailed error
// - Bus reset flag once per 2.5 us reset
// - Flags interrupt only when enabled
// - Change flags record cable, tick, line, voltages
package uolc_pkg;
  // ==========================================================
  // Timing
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned NS_PER_MS = 1000000;
  localparam real QUIET_TIME_US = 2.5;
  localparam int unsigned DEBOUNCE_TIME_MS = 1;
  localparam int unsigned SLEEP_TIME_MS = 3;
  localparam int unsigned QUIET_CYC = int'($ceil(QUIET_TIME_US * 1000.0 / CLK_PERIOD_NS));
  localparam int unsigned DEBOUNCE_CYC = DEBOUNCE_TIME_MS * NS_PER_MS / CLK_PERIOD_NS;
  localparam int unsigned SLEEP_CYC = SLEEP_TIME_MS * NS_PER_MS / CLK_PERIOD_NS;
  localparam int unsigned CNT_W = 19;
  // ==========================================================
  // Register offsets (byte addresses, low byte of haddr)
  localparam logic [7:0] OFS_OTG_CHG = 8'h10;
  localparam logic [7:0] OFS_OTG_CHG_EN = 8'h14;
  localparam logic [7:0] OFS_OTG_STAT = 8'h18;
  localparam logic [7:0] OFS_OTG_CTL = 8'h1c;
  localparam logic [7:0] OFS_ISTAT = 8'h80;
  localparam logic [7:0] OFS_IEN = 8'h84;
  localparam logic [7:0] OFS_XSTAT = 8'h90;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [2:0] SIZE_WORD = 3'h2;
  // ==========================================================
  // Field positions
  localparam int OTG_CABLE = 7, OTG_TICK = 6, OTG_LINE = 5;
  localparam int OTG_BSESS_VALID = 3, OTG_BSESS_END = 2, OTG_ABUS_VALID = 0;
  localparam logic [7:0] OTG_MASK = 8'hed;
  localparam int CTL_DP_UP = 7, CTL_DM_UP = 6, CTL_DP_DN = 5, CTL_DM_DN = 4;
  localparam int CTL_SUPPLY = 3, CTL_LINE_EN = 2, CTL_CHARGE = 1, CTL_DISCHARGE = 0;
  localparam int IRQ_STALL = 7, IRQ_ATTACH = 6, IRQ_RESUME = 5, IRQ_SLEEP = 4;
  localparam int IRQ_TOKEN = 3, IRQ_FRAME = 2, IRQ_ERROR = 1, IRQ_BUS_RESET = 0;
  localparam logic [7:0] IRQ_W1C_MASK = 8'hc8;
  localparam logic [7:0] IRQ_RW_MASK = 8'h37;
  // ==========================================================
  // Carriers
  typedef struct packed {
    logic j;
    logic se0;
  } uolc_line_t;
  localparam uolc_line_t LINE_IDLE = '{j: 1'b1, se0: 1'b0};
  typedef struct packed {
    logic b_session_valid;
    logic b_session_end;
    logic a_bus_valid;
  } uolc_vbus_t;
  typedef struct packed {
    logic stall;
    logic token_complete;
    logic frame_rx;
    logic frame_threshold;
    logic error;
  } uolc_evt_t;
  typedef struct packed {
    logic dplus_pullup;
    logic dminus_pullup;
    logic dplus_pulldown;
    logic dminus_pulldown;
    logic supply_switch;
    logic supply_charge;
    logic supply_discharge;
  } uolc_pad_t;
endpackage

// ### uolc_top.sv
`timescale 1ns/1ps
`default_nettype none
module uolc_top
  import uolc_pkg::*;
#(
  parameter int unsigned DEBOUNCE_CYCLES = DEBOUNCE_CYC,
  parameter int unsigned SLEEP_CYCLES = SLEEP_CYC
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Cable and comparators
  input wire logic cable_type,
  input wire uolc_line_t line,
  input wire uolc_vbus_t vbus,
  // Controller side
  input wire logic ctrl_enable,
  input wire logic host_mode,
  input wire uolc_evt_t evt,
  input wire logic [7:0] token_status,
  // Pad controls and interrupts
  output uolc_pad_t pads,
  output logic usb_irq,
  output logic otg_irq
);
  // ==========================================================
  // Counter limits
  localparam logic [CNT_W-1:0] QUIET_LAST = CNT_W'(QUIET_CYC - 1);
  localparam logic [CNT_W-1:0] DEB_LAST = CNT_W'(DEBOUNCE_CYCLES - 1);
  localparam logic [CNT_W-1:0] DEB_FULL = CNT_W'(DEBOUNCE_CYCLES);
  localparam logic [CNT_W-1:0] SLEEP_LAST = CNT_W'(SLEEP_CYCLES - 1);
  localparam logic [CNT_W-1:0] SLEEP_FULL = CNT_W'(SLEEP_CYCLES);
  localparam logic [CNT_W-1:0] CNT_ZERO = '0;
  localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);

  uolc_line_t line_q; // Line value one cycle ago
  uolc_line_t stable_val; // Last debounced line value
  logic [CNT_W-1:0] quiet_cnt; // Cycles since last line change
  logic [CNT_W-1:0] sleep_cnt; // Cycles of continuous idle
  logic [CNT_W-1:0] tick_cnt; // Free-running millisecond divider
  logic tick_phase; // Toggles every millisecond
  logic line_chg, quiet_hit, deb_hit, sleep_hit, tick;
  logic line_k, line_idle, line_stable;
  logic attach_hit, resume_hit, reset_hit;
  logic [7:0] otg_stat; // Snapshot of line and voltage status
  logic [7:0] otg_chg; // Change flags, write one to clear
  logic [7:0] otg_chg_en; // Change flag enables
  logic [7:0] otg_ctl; // Line resistor and supply controls
  logic [7:0] istat; // Main event flags
  logic [7:0] ien; // Main event enables
  logic [7:0] xstat; // Presented transaction status
  logic [7:0] hold; // Queued transaction status
  logic hold_valid;
  logic [7:0] next_istat, next_otg_chg, istat_set, otg_set, next_rdata;
  logic wr_pend; // Write data phase in progress
  logic [7:0] wr_off;
  logic [7:0] wdata;
  logic wr_istat, token_complete_clr, token_complete_set, line_en_eff;
  uolc_pad_t next_pads;

  // ==========================================================
  // Line activity detection
  assign line_chg = (line != line_q);
  assign line_k = !line.j && !line.se0;
  assign line_idle = line.j && !line.se0;
  assign quiet_hit = !line_chg && (quiet_cnt == QUIET_LAST);
  assign deb_hit = !line_chg && (quiet_cnt == DEB_LAST);
  assign line_stable = (quiet_cnt == DEB_FULL);
  assign sleep_hit = line_idle && !line_chg && (sleep_cnt == SLEEP_LAST);
  assign tick = (tick_cnt == DEB_LAST);
  // A single quiet count serves attach, resume and reset; each fires once per steady stretch
  assign attach_hit = host_mode && quiet_hit && !line.se0;
  assign resume_hit = quiet_hit && line_k;
  assign reset_hit = quiet_hit && line.se0;

  // Previous line sample
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      line_q <= LINE_IDLE; // Idle J, so leaving reset is not taken for line activity
    end else begin
      line_q <= line;
    end
  end

  // Quiet counter, saturates at the debounce interval
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      quiet_cnt <= CNT_ZERO;
    end else if (line_chg) begin
      quiet_cnt <= CNT_ZERO;
    end else if (quiet_cnt != DEB_FULL) begin
      quiet_cnt <= quiet_cnt + CNT_ONE;
    end
  end

  // Idle timer; any activity or non-idle state restarts it
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sleep_cnt <= CNT_ZERO;
    end else if (line_chg || !line_idle) begin
      sleep_cnt <= CNT_ZERO;
    end else if (sleep_cnt != SLEEP_FULL) begin
      sleep_cnt <= sleep_cnt + CNT_ONE;
    end
  end

  // Millisecond divider
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tick_cnt <= CNT_ZERO;
      tick_phase <= 1'b0;
    end else if (tick) begin
      tick_cnt <= CNT_ZERO;
      tick_phase <= !tick_phase;
    end else begin
      tick_cnt <= tick_cnt + CNT_ONE;
    end
  end

  // Last debounced value, to spot a genuinely new line state
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      stable_val <= LINE_IDLE; // Idle J, so the first debounce flags no false change
    end else if (deb_hit) begin
      stable_val <= line;
    end
  end

  // ==========================================================
  // Line and voltage status snapshot
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      otg_stat <= REG_RESET;
    end else begin
      otg_stat <= REG_RESET;
      otg_stat[OTG_CABLE] <= cable_type;
      otg_stat[OTG_TICK] <= tick_phase;
      otg_stat[OTG_LINE] <= line_stable;
      otg_stat[OTG_BSESS_VALID] <= vbus.b_session_valid;
      otg_stat[OTG_BSESS_END] <= vbus.b_session_end;
      otg_stat[OTG_ABUS_VALID] <= vbus.a_bus_valid;
    end
  end

  // Cable and voltage events compare live inputs with the snapshot; tick and debounced line events do not
  always_comb begin
    otg_set = REG_RESET;
    otg_set[OTG_CABLE] = cable_type ^ otg_stat[OTG_CABLE];
    otg_set[OTG_TICK] = tick;
    otg_set[OTG_LINE] = deb_hit && (line != stable_val);
    otg_set[OTG_BSESS_VALID] = vbus.b_session_valid ^ otg_stat[OTG_BSESS_VALID];
    otg_set[OTG_BSESS_END] = vbus.b_session_end ^ otg_stat[OTG_BSESS_END];
    otg_set[OTG_ABUS_VALID] = vbus.a_bus_valid ^ otg_stat[OTG_ABUS_VALID];
  end

  // ==========================================================
  // AHB-Lite slave: zero wait states, always OKAY
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign wdata = hwdata[7:0];
  assign wr_istat = wr_pend && (wr_off == OFS_ISTAT);

  // Address phase capture; only aligned word accesses in the low page decode
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      wr_off <= REG_RESET;
    end else if (hready) begin
      wr_pend <= hsel && htrans[1] && hwrite && (hsize == SIZE_WORD) && (haddr[31:8] == '0);
      wr_off <= haddr[7:0];
    end
  end

  // Read mux; unmapped offsets read zero
  always_comb begin
    next_rdata = REG_RESET;
    unique case (haddr[7:0])
      OFS_OTG_CHG: next_rdata = otg_chg;
      OFS_OTG_CHG_EN: next_rdata = otg_chg_en;
      OFS_OTG_STAT: next_rdata = otg_stat;
      OFS_OTG_CTL: next_rdata = otg_ctl;
      OFS_ISTAT: next_rdata = istat;
      OFS_IEN: next_rdata = ien;
      OFS_XSTAT: next_rdata = xstat;
      default: next_rdata = REG_RESET;
    endcase
    if (haddr[31:8] != '0 || hsize != SIZE_WORD) begin
      next_rdata = REG_RESET;
    end
  end

  // Read data registered at the address phase, valid through the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= '0;
    end else if (hready && hsel && htrans[1] && !hwrite) begin
      hrdata <= {24'h000000, next_rdata};
    end
  end

  // Plain control and enable registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      otg_ctl <= REG_RESET;
      otg_chg_en <= REG_RESET;
      ien <= REG_RESET;
    end else if (wr_pend) begin
      if (wr_off == OFS_OTG_CTL) begin
        otg_ctl <= wdata & ~OTG_MASK | wdata & OTG_MASK;
      end
      if (wr_off == OFS_OTG_CHG_EN) begin
        otg_chg_en <= wdata & OTG_MASK;
      end
      if (wr_off == OFS_IEN) begin
        ien <= wdata;
      end
    end
  end

  // Change flags: write one clears, a new event in the same cycle wins
  always_comb begin
    next_otg_chg = otg_chg;
    if (wr_pend && wr_off == OFS_OTG_CHG) begin
      next_otg_chg = otg_chg & ~wdata;
    end
    next_otg_chg = (next_otg_chg | otg_set) & OTG_MASK;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      otg_chg <= REG_RESET;
    end else begin
      otg_chg <= next_otg_chg;
    end
  end

  // ==========================================================
  // Main event flags
  assign token_complete_clr = wr_istat && wdata[IRQ_TOKEN] && istat[IRQ_TOKEN];
  // A clear with a queued status re-presents the flag at once
  assign token_complete_set = evt.token_complete || (token_complete_clr && hold_valid);

  always_comb begin
    istat_set = REG_RESET;
    istat_set[IRQ_STALL] = evt.stall;
    istat_set[IRQ_ATTACH] = attach_hit;
    istat_set[IRQ_RESUME] = resume_hit;
    istat_set[IRQ_SLEEP] = sleep_hit;
    istat_set[IRQ_TOKEN] = token_complete_set;
    istat_set[IRQ_FRAME] = host_mode ? evt.frame_threshold : evt.frame_rx;
    istat_set[IRQ_ERROR] = evt.error;
    istat_set[IRQ_BUS_RESET] = reset_hit;
  end

  // Clearable bits clear on one, plain bits take the written value; hardware set wins
  always_comb begin
    next_istat = istat;
    if (wr_istat) begin
      next_istat = istat & ~(wdata & IRQ_W1C_MASK);
      next_istat = (next_istat & ~IRQ_RW_MASK) | (wdata & IRQ_RW_MASK);
    end
    next_istat = next_istat | istat_set;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      istat <= REG_RESET;
    end else begin
      istat <= next_istat;
    end
  end

  // Transaction status and its one-deep holding slot; a third queued completion is lost
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      xstat <= REG_RESET;
      hold <= REG_RESET;
      hold_valid <= 1'b0;
    end else if (token_complete_clr) begin
      if (hold_valid) begin
        xstat <= hold;
        hold <= token_status;
        hold_valid <= evt.token_complete;
      end else begin
        xstat <= evt.token_complete ? token_status : REG_RESET;
      end
    end else if (evt.token_complete) begin
      if (!istat[IRQ_TOKEN]) begin
        xstat <= token_status;
      end else if (!hold_valid) begin
        hold <= token_status;
        hold_valid <= 1'b1;
      end
    end
  end

  // ==========================================================
  // Pad control
  assign line_en_eff = ctrl_enable && otg_ctl[CTL_LINE_EN];

  always_comb begin
    next_pads = '0;
    next_pads.supply_switch = otg_ctl[CTL_SUPPLY];
    next_pads.supply_charge = otg_ctl[CTL_CHARGE];
    next_pads.supply_discharge = otg_ctl[CTL_DISCHARGE];
    if (line_en_eff) begin
      next_pads.dplus_pullup = otg_ctl[CTL_DP_UP];
      next_pads.dminus_pullup = otg_ctl[CTL_DM_UP];
      next_pads.dplus_pulldown = otg_ctl[CTL_DP_DN];
      next_pads.dminus_pulldown = otg_ctl[CTL_DM_DN];
    end else if (!host_mode) begin
      next_pads.dplus_pullup = 1'b1;
    end else if (ctrl_enable) begin
      next_pads.dplus_pulldown = 1'b1;
      next_pads.dminus_pulldown = 1'b1;
    end
  end

  // Pads and interrupt lines come from flops
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pads <= '0;
      usb_irq <= 1'b0;
      otg_irq <= 1'b0;
    end else begin
      pads <= next_pads;
      usb_irq <= |(istat & ien);
      otg_irq <= |(otg_chg & otg_chg_en);
    end
  end

  // ==========================================================
  // Assertions
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  cable_status_a: assert property ($past(hresetn) |-> otg_stat[OTG_CABLE] == $past(cable_type))
    else $error("cable status wrong");
  debounce_stable_a: assert property ($rose(otg_stat[OTG_LINE]) |-> $past(line, 2) == $past(line, 3))
    else $error("line stable without quiet lines");
  bsess_valid_a: assert property (otg_stat[OTG_BSESS_VALID] == $past(vbus.b_session_valid))
    else $error("session valid status wrong");
  bsess_end_a: assert property (otg_stat[OTG_BSESS_END] == $past(vbus.b_session_end))
    else $error("session end status wrong");
  abus_valid_a: assert property (otg_stat[OTG_ABUS_VALID] == $past(vbus.a_bus_valid))
    else $error("bus valid status wrong");
  resistor_follow_a: assert property (line_en_eff |=> pads.dminus_pullup == $past(otg_ctl[CTL_DM_UP]))
    else $error("resistor not following control");
  supply_on_a: assert property (pads.supply_switch == $past(otg_ctl[CTL_SUPPLY]))
    else $error("supply switch wrong");
  line_en_gate_a: assert property ($past(hresetn) && !ctrl_enable && !host_mode
    |=> pads.dplus_pullup && !pads.dplus_pulldown)
    else $error("line enable used while controller off");
  auto_pullup_a: assert property ($past(hresetn) && !otg_ctl[CTL_LINE_EN] && !host_mode
    |=> pads.dplus_pullup)
    else $error("automatic pull-up missing");
  host_pulldown_a: assert property (!line_en_eff && host_mode && ctrl_enable
    |=> pads.dplus_pulldown && pads.dminus_pulldown && !pads.dplus_pullup)
    else $error("host pull-downs missing");
  charge_a: assert property (pads.supply_charge == $past(otg_ctl[CTL_CHARGE]))
    else $error("charge control wrong");
  stall_set_a: assert property (evt.stall |=> istat[IRQ_STALL])
    else $error("stall flag not set");
  attach_host_a: assert property ($rose(istat[IRQ_ATTACH]) |-> $past(host_mode) && !$past(line.se0))
    else $error("attach outside host mode");
  resume_after_a: assert property (line_k && quiet_cnt == QUIET_LAST && !line_chg |=> istat[IRQ_RESUME])
    else $error("resume flag missing");
  sleep_after_a: assert property (sleep_hit |-> line_idle ##1 istat[IRQ_SLEEP])
    else $error("sleep flag missing");
  token_set_a: assert property (evt.token_complete |=> istat[IRQ_TOKEN])
    else $error("token flag not set");
  token_hold_a: assert property (token_complete_clr && hold_valid |=> xstat == $past(hold) && istat[IRQ_TOKEN])
    else $error("held status not presented");
  frame_host_a: assert property (host_mode && evt.frame_threshold |=> istat[IRQ_FRAME])
    else $error("frame flag missing");
  error_set_a: assert property (evt.error |=> istat[IRQ_ERROR])
    else $error("error flag missing");
  reset_once_a: assert property (reset_hit |=> !reset_hit)
    else $error("bus reset seen twice");
  irq_gate_a: assert property (usb_irq == $past(|(istat & ien)))
    else $error("interrupt not gated by enables");
  tick_flag_a: assert property (tick |=> otg_chg[OTG_TICK])
    else $error("tick change flag missing");

  attach_seen_c: cover property (attach_hit);
  hold_used_c: cover property (token_complete_clr && hold_valid);
  sleep_seen_c: cover property (sleep_hit);
  reset_seen_c: cover property (reset_hit ##1 istat[IRQ_BUS_RESET]);
endmodule
`default_nettype wire

// ### uolc_cable_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Far side of the cable: a host or peripheral that sets the line
// state, the connector sense and the supply level on clock edges
module uolc_cable_model
  import uolc_pkg::*;
(
  // Clock
  input wire logic hclk,
  // Wanted cable conditions
  input wire uolc_line_t want_line,
  input wire logic want_cable,
  input wire uolc_vbus_t want_vbus,
  // Cable side as seen by the block
  output uolc_line_t line,
  output logic cable_type,
  output uolc_vbus_t vbus
);
  // Lines only move on an edge, so the quiet counter sees whole cycles
  always_ff @(posedge hclk) begin
    line <= want_line;
    cable_type <= want_cable;
    vbus <= want_vbus;
  end
endmodule
`default_nettype wire

// ### usb_otg_line_control_and_irq_status_tb.sv
`timescale 1ns/1ps
`default_nettype none
module usb_otg_line_control_and_irq_status_tb;
  import uolc_pkg::*;
  // ==========================================================
  // Signals
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, cable = 1, ctrl_en = 0, host = 0;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, r;
  logic [1:0] htrans = 0;
  logic [2:0] hsize = SIZE_WORD;
  logic hreadyout, hresp, usb_irq, otg_irq, cable_type;
  uolc_line_t want = '{j: 1'b1, se0: 1'b0}, line;
  uolc_vbus_t wvb = '0, vbus;
  uolc_evt_t evt = '0;
  uolc_pad_t pads;
  logic [7:0] tok = 0, s1, s2, c;
  logic [7:0] addrs [6] = '{8'h1c, 8'h80, 8'h84, 8'h14, 8'h90, 8'h40};
  int num_errors = 0, cmp_count = 0, cycles = 0;
  // Short counts keep the run brief; timings below derive from them
  localparam int unsigned DEB = 300, SLP = 400;
  // ==========================================================
  // Clock, model and design
  initial forever #5 hclk = ~hclk;
  uolc_cable_model uolc_cable_model_i (.hclk(hclk), .want_line(want), .want_cable(cable),
    .want_vbus(wvb), .line(line), .cable_type(cable_type), .vbus(vbus));
  uolc_top #(.DEBOUNCE_CYCLES(DEB), .SLEEP_CYCLES(SLP)) uolc_top_i (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout),
    .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .cable_type(cable_type),
    .line(line), .vbus(vbus), .ctrl_enable(ctrl_en), .host_mode(host), .evt(evt),
    .token_status(tok), .pads(pads), .usb_irq(usb_irq), .otg_irq(otg_irq));
  // ==========================================================
  // Helpers
  task automatic final_report();
    $display("errors=%0d compares=%0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Hang guard: generous against the few thousand cycles used
  always @(posedge hclk) begin
    cycles++;
    if (cycles == 30000) begin
      num_errors++;
      final_report();
    end
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      num_errors++;
      $display("[ERR] t=%0t seen=%h expected=%h", $time, g, e);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge hclk);
  endtask
  // One single AHB transfer, entered just after a rising edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hsel <= 0;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    r = hrdata;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    bus(0, a, 0);
    chk(r & m, e);
  endtask
  task automatic pulse(input logic [4:0] e);
    evt <= uolc_evt_t'(e);
    @(posedge hclk);
    evt <= '0;
    @(posedge hclk);
  endtask
  // Resistor state: own controls only with both enables, else automatic
  function automatic logic [31:0] exp_pads(input logic [7:0] k, input logic en, input logic h);
    logic [3:0] res;
    if (en && k[2]) res = k[7:4];
    else if (!h) res = 4'h8;
    else if (en) res = 4'h3;
    else res = 4'h0;
    return {25'h0, res, k[3], k[1], k[0]};
  endfunction
  // ==========================================================
  // Main sequence
  initial begin
    void'($urandom(32'hbe1532fb));
    repeat (16) @(posedge hclk);
    hresetn <= 1;
    @(posedge hclk);
    foreach (addrs[i]) rd(addrs[i], 32'hffffffff, 0);
    bus(1, 8'h40, 32'hff);
    rd(8'h40, 32'hffffffff, 0);
    chk({31'h0, hresp}, 0); // Response always OKAY
    // Connector and comparator snapshot
    repeat (8) begin
      cable <= 1'($urandom);
      wvb <= uolc_vbus_t'(3'($urandom));
      wt(3);
      rd(8'h18, 32'h8d, {24'h0, cable, 3'h0, wvb.b_session_valid, wvb.b_session_end, 1'b0, wvb.a_bus_valid});
    end
    cable <= 1;
    // Line resistors and supply controls over 16 random enable mixes
    repeat (16) begin
      c = 8'($urandom);
      ctrl_en <= 1'($urandom);
      host <= 1'($urandom);
      bus(1, 8'h1c, {24'h0, c});
      wt(2);
      chk({25'h0, pads}, exp_pads(c, ctrl_en, host));
    end
    rd(8'h1c, 32'hff, {24'h0, c});
    ctrl_en <= 1;
    host <= 0;
    bus(1, 8'h1c, 0);
    // Debounce, sleep and its restart
    want <= '{j: 1'b0, se0: 1'b0};
    wt(1);
    want <= '{j: 1'b1, se0: 1'b0};
    wt(DEB + 20);
    rd(8'h18, 32'h20, 32'h20);
    rd(8'h80, 32'h50, 0);
    wt(90);
    rd(8'h80, 32'h10, 32'h10);
    bus(1, 8'h80, 0);
    want <= '{j: 1'b0, se0: 1'b0};
    wt(1);
    want <= '{j: 1'b1, se0: 1'b0};
    wt(300);
    rd(8'h80, 32'h10, 0);
    wt(110);
    rd(8'h80, 32'h10, 32'h10);
    // Resume, bus reset once per stretch, host attach
    want <= '{j: 1'b0, se0: 1'b0};
    wt(230);
    rd(8'h80, 32'h20, 0);
    wt(30);
    rd(8'h80, 32'h20, 32'h20);
    want <= '{j: 1'b0, se0: 1'b1};
    wt(270);
    rd(8'h80, 32'h01, 32'h01);
    bus(1, 8'h80, 0);
    wt(300);
    rd(8'h80, 32'h01, 0);
    host <= 1;
    want <= '{j: 1'b1, se0: 1'b0};
    wt(270);
    rd(8'h80, 32'h40, 32'h40);
    bus(1, 8'h80, 32'h40);
    rd(8'h80, 32'h40, 0);
    host <= 0;
    // Stall, queued token completions, frame, error
    pulse(5'h10);
    rd(8'h80, 32'h80, 32'h80);
    bus(1, 8'h80, 32'h80);
    rd(8'h80, 32'h80, 0);
    s1 = 8'($urandom);
    s2 = 8'($urandom);
    tok <= s1;
    pulse(5'h08);
    tok <= s2;
    pulse(5'h08);
    rd(8'h90, 32'hff, {24'h0, s1});
    rd(8'h80, 32'h08, 32'h08);
    bus(1, 8'h80, 32'h08);
    rd(8'h90, 32'hff, {24'h0, s2});
    rd(8'h80, 32'h08, 32'h08);
    bus(1, 8'h80, 32'h08);
    rd(8'h90, 32'hff, 0);
    rd(8'h80, 32'h08, 0);
    for (int m = 0; m < 2; m++) begin
      host <= m[0];
      bus(1, 8'h80, 0);
      pulse(m[0] ? 5'h04 : 5'h02);
      rd(8'h80, 32'h04, 0);
      pulse(m[0] ? 5'h02 : 5'h04);
      rd(8'h80, 32'h04, 32'h04);
    end
    host <= 0;
    pulse(5'h01);
    rd(8'h80, 32'h02, 32'h02);
    // Interrupt masking, main and change flags
    bus(1, 8'h80, 32'hc8);
    bus(1, 8'h80, 0);
    bus(1, 8'h84, 32'h80);
    wt(2);
    chk({31'h0, usb_irq}, 0);
    pulse(5'h10);
    wt(2);
    chk({31'h0, usb_irq}, 1);
    bus(1, 8'h84, 0);
    wt(2);
    chk({31'h0, usb_irq}, 0);
    bus(1, 8'h10, 32'hff);
    bus(1, 8'h14, 32'h80);
    wt(2);
    chk({31'h0, otg_irq}, 0);
    cable <= 0;
    wt(5);
    chk({31'h0, otg_irq}, 1);
    rd(8'h10, 32'h80, 32'h80);
    bus(1, 8'h10, 32'h80);
    wt(2);
    chk({31'h0, otg_irq}, 0);
    // Every comparator flips, so each voltage change flag must rise
    wvb <= uolc_vbus_t'(~wvb);
    wt(5);
    rd(8'h10, 32'h0d, 32'h0d);
    final_report();
  end
endmodule
`default_nettype wire
